//--- rtl/uhir_pkg.sv
package uhir_pkg;
    // Register offsets (byte addresses on the processor register bus)
    localparam logic [15:0] HOST1_TARGET_DEVICE_ADDRESS = 16'hc088;
    localparam logic [15:0] HOST1_INTERRUPT_ENABLE = 16'hc08c;
    localparam logic [15:0] HOST1_STATUS = 16'hc090;
    localparam logic [15:0] HOST2_TARGET_DEVICE_ADDRESS = 16'hc0a8;
    localparam logic [15:0] HOST2_INTERRUPT_ENABLE = 16'hc0ac;
    localparam logic [15:0] HOST2_STATUS = 16'hc0b0;
    // Field positions
    localparam int BIT_VBUS = 15;
    localparam int BIT_ID = 14;
    localparam int BIT_SOF = 9;
    localparam int BIT_WAKE_B = 7;
    localparam int BIT_WAKE_A = 6;
    localparam int BIT_CONN_B = 5;
    localparam int BIT_CONN_A = 4;
    localparam int BIT_SE0_B = 3;
    localparam int BIT_SE0_A = 2;
    localparam int BIT_DONE = 0;
    localparam int ADDR_W = 7;
    // Reset values
    localparam logic [6:0] ADDR_RESET = 7'h00;
    localparam logic [15:0] ENABLE_RESET = 16'h0000;
    localparam logic [15:0] FLAGS_RESET = 16'h0000;
    // Implemented enable and flag bits per host instance
    localparam logic [15:0] HOST1_IRQ_MASK = 16'hc2f1;
    localparam logic [15:0] HOST2_IRQ_MASK = 16'h02f1;
    // Sticky flag bits (SE0 status bits are live levels)
    localparam logic [15:0] STICKY_MASK = 16'hc2f1;
    localparam logic [15:0] SE0_MASK = 16'h000c;
endpackage

//--- rtl/uhir_edge.sv
`timescale 1ns/1ns
module uhir_edge
    import uhir_pkg::*;
(
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic level_in,
    output logic toggle_out
);
    logic level_reg;

    // Pulses on either edge of a synchronous level
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            // Track the pin in reset so release never shows a false edge
            level_reg <= level_in;
        end else begin
            level_reg <= level_in;
        end
    end

    assign toggle_out = (level_reg != level_in) & ~srst_in;
endmodule

//--- rtl/uhir_host.sv
`timescale 1ns/1ns
module uhir_host
    import uhir_pkg::*;
#(
    parameter logic [15:0] IMPL_MASK = HOST1_IRQ_MASK
) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic addr_we_in,
    input wire logic en_we_in,
    input wire logic st_we_in,
    input wire logic [15:0] wdata_in,
    input wire logic [15:0] set_in,
    input wire logic [1:0] se0_in,
    output logic [6:0] dev_addr_out,
    output logic [15:0] enable_out,
    output logic [15:0] status_out,
    output logic irq_out
);
    logic [6:0] addr_reg;
    logic [15:0] en_reg;
    logic [15:0] flag_reg;
    logic [15:0] flag_next;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            addr_reg <= ADDR_RESET;
        end else if (addr_we_in) begin
            addr_reg <= wdata_in[ADDR_W-1:0]; // [R1]
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            en_reg <= ENABLE_RESET;
        end else if (en_we_in) begin
            en_reg <= wdata_in & IMPL_MASK; // [R3] [R4] [R5]
        end
    end

    // Write one clears; a same-cycle event keeps the flag set
    always_comb begin
        flag_next = flag_reg;
        if (st_we_in) begin
            flag_next = flag_next & ~wdata_in; // [R10]
        end
        flag_next = (flag_next | set_in) & IMPL_MASK & STICKY_MASK; // [R20]
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            flag_reg <= FLAGS_RESET;
        end else begin
            flag_reg <= flag_next;
        end
    end

    always_comb begin
        status_out = flag_reg; // [R14]
        status_out[BIT_SE0_B] = se0_in[1]; // [R17]
        status_out[BIT_SE0_A] = se0_in[0]; // [R17]
    end

    assign dev_addr_out = addr_reg;
    assign enable_out = en_reg;
    assign irq_out = |(flag_reg & en_reg); // [R19]
endmodule

//--- rtl/uhir_top.sv
`timescale 1ns/1ns
// Behaviour
// (R1) Write-only 7-bit target address, used for the next host transaction.
// (R2) Software writes zeros into reserved address register bits.
// (R3) Enable bit one enables its interrupt source, zero disables it.
// (R4) Bit 15 gates VBUS 4.4V both-edge interrupt, host 1 only.
// (R5) Bit 14 gates ID pin both-edge interrupt, host 1 only.
// (R6) Bit 9 gates the SOF/EOP frame timer interrupt.
// (R7) Bits 7 and 6 gate port B and port A remote wakeup.
// (R8) Bits 5 and 4 gate connect change on SE0/J transitions.
// (R9) Bit 0 gates shared transfer-done on ACK, NAK, STALL or timeout.
// (R10) Writing one clears a pending flag; zero leaves it.
// (R11) Status readable and writable from processor and external host port.
// (R12) Status bit 15 set on VBUS edge, host 1 only.
// (R13) Status bit 14 set on ID edge, host 1 only.
// (R14) Flags at 9, 7, 6, 5, 4, SE0 at 3, 2, done at 0.
// (R15) Two independent hosts; host 2 enable register at 0xC0AC.
// (R16) Frame timer flag set when SOF/EOP counter expires.
// (R17) SE0 status reads one while the port lines are in SE0.
// (R18) Wake flag set when remote wakeup detected on that port.
// (R19) Interrupt output asserted when any enabled flag is set.
// (R20) Source event wins over a same-cycle write-one-to-clear.
module uhir_top
    import uhir_pkg::*;
(
    // Clock and reset
    input wire logic MCLK_IN,
    input wire logic SRST_IN,
    // Processor register port
    input wire logic CPU_WE_IN,
    input wire logic CPU_RE_IN,
    input wire logic [15:0] CPU_ADDR_IN,
    input wire logic [15:0] CPU_WDATA_IN,
    output logic [15:0] CPU_RDATA_OUT,
    // External host port register access
    input wire logic EXT_HOST_PORT_WE_IN,
    input wire logic EXT_HOST_PORT_RE_IN,
    input wire logic [15:0] EXT_HOST_PORT_ADDR_IN,
    input wire logic [15:0] EXT_HOST_PORT_WDATA_IN,
    output logic [15:0] EXT_HOST_PORT_RDATA_OUT,
    // First engine port A OTG levels
    input wire logic FIRST_ENGINE_PORT_A_VBUS_VALID_IN,
    input wire logic FIRST_ENGINE_PORT_A_ID_IN,
    // Per host events: index 0 is host 1, index 1 is host 2
    input wire logic [1:0] SOF_EXPIRE_IN,
    input wire logic [1:0] WAKE_A_IN,
    input wire logic [1:0] WAKE_B_IN,
    input wire logic [1:0] SE0_A_IN,
    input wire logic [1:0] SE0_B_IN,
    input wire logic [1:0] XFER_DONE_IN,
    // Host outputs
    output logic [6:0] HOST1_DEV_ADDR_OUT,
    output logic [6:0] HOST2_DEV_ADDR_OUT,
    output logic [1:0] HOST_IRQ_OUT
);
    ////////////////////////////////////////////////////////////////////
    logic vbus_edge;
    logic id_edge;
    logic [1:0] conn_a_edge;
    logic [1:0] conn_b_edge;
    logic [1:0] addr_we;
    logic [1:0] en_we;
    logic [1:0] st_we;
    logic [15:0] wdata;
    logic [15:0] set_vec [2];
    logic [15:0] en_vec [2];
    logic [15:0] st_vec [2];
    logic [6:0] addr_vec [2];
    logic [15:0] cpu_rd_reg;
    logic [15:0] ext_rd_reg;

    uhir_edge u_vbus_edge (
        .clk_in(MCLK_IN),
        .srst_in(SRST_IN),
        .level_in(FIRST_ENGINE_PORT_A_VBUS_VALID_IN),
        .toggle_out(vbus_edge)
    );

    uhir_edge u_id_edge (
        .clk_in(MCLK_IN),
        .srst_in(SRST_IN),
        .level_in(FIRST_ENGINE_PORT_A_ID_IN),
        .toggle_out(id_edge)
    );

    ////////////////////////////////////////////////////////////////////
    // Processor write takes priority over a same-cycle port write
    assign wdata = CPU_WE_IN ? CPU_WDATA_IN : EXT_HOST_PORT_WDATA_IN;

    genvar h;
    generate
        for (h = 0; h < 2; h = h + 1) begin : g_host
            localparam logic [15:0] A_OFS =
                (h == 0) ? HOST1_TARGET_DEVICE_ADDRESS
                         : HOST2_TARGET_DEVICE_ADDRESS;
            localparam logic [15:0] E_OFS =
                (h == 0) ? HOST1_INTERRUPT_ENABLE
                         : HOST2_INTERRUPT_ENABLE; // [R15]
            localparam logic [15:0] S_OFS =
                (h == 0) ? HOST1_STATUS : HOST2_STATUS;
            localparam logic [15:0] MASK =
                (h == 0) ? HOST1_IRQ_MASK : HOST2_IRQ_MASK;
            logic cpu_hit_a;
            logic cpu_hit_e;
            logic cpu_hit_s;
            logic ext_hit_a;
            logic ext_hit_e;
            logic ext_hit_s;

            assign cpu_hit_a = CPU_WE_IN && CPU_ADDR_IN == A_OFS;
            assign cpu_hit_e = CPU_WE_IN && CPU_ADDR_IN == E_OFS;
            assign cpu_hit_s = CPU_WE_IN && CPU_ADDR_IN == S_OFS;
            assign ext_hit_a = !CPU_WE_IN && EXT_HOST_PORT_WE_IN &&
                EXT_HOST_PORT_ADDR_IN == A_OFS;
            assign ext_hit_e = !CPU_WE_IN && EXT_HOST_PORT_WE_IN &&
                EXT_HOST_PORT_ADDR_IN == E_OFS;
            assign ext_hit_s = !CPU_WE_IN && EXT_HOST_PORT_WE_IN &&
                EXT_HOST_PORT_ADDR_IN == S_OFS; // [R11]
            assign addr_we[h] = cpu_hit_a | ext_hit_a;
            assign en_we[h] = cpu_hit_e | ext_hit_e;
            assign st_we[h] = cpu_hit_s | ext_hit_s;

            always_comb begin
                set_vec[h] = 16'h0000;
                if (h == 0) begin
                    set_vec[h][BIT_VBUS] = vbus_edge; // [R12]
                    set_vec[h][BIT_ID] = id_edge; // [R13]
                end
                set_vec[h][BIT_SOF] = SOF_EXPIRE_IN[h]; // [R16] [R6]
                set_vec[h][BIT_WAKE_B] = WAKE_B_IN[h]; // [R18] [R7]
                set_vec[h][BIT_WAKE_A] = WAKE_A_IN[h]; // [R18] [R7]
                set_vec[h][BIT_CONN_B] = conn_b_edge[h]; // [R8]
                set_vec[h][BIT_CONN_A] = conn_a_edge[h]; // [R8]
                set_vec[h][BIT_DONE] = XFER_DONE_IN[h]; // [R9]
            end

            uhir_edge u_conn_a (
                .clk_in(MCLK_IN),
                .srst_in(SRST_IN),
                .level_in(SE0_A_IN[h]),
                .toggle_out(conn_a_edge[h])
            );

            uhir_edge u_conn_b (
                .clk_in(MCLK_IN),
                .srst_in(SRST_IN),
                .level_in(SE0_B_IN[h]),
                .toggle_out(conn_b_edge[h])
            );

            uhir_host #(
                .IMPL_MASK(MASK)
            ) u_host (
                .clk_in(MCLK_IN),
                .srst_in(SRST_IN),
                .addr_we_in(addr_we[h]),
                .en_we_in(en_we[h]),
                .st_we_in(st_we[h]),
                .wdata_in(wdata),
                .set_in(set_vec[h]),
                .se0_in({SE0_B_IN[h], SE0_A_IN[h]}),
                .dev_addr_out(addr_vec[h]),
                .enable_out(en_vec[h]),
                .status_out(st_vec[h]),
                .irq_out(HOST_IRQ_OUT[h])
            );
        end
    endgenerate

    assign HOST1_DEV_ADDR_OUT = addr_vec[0];
    assign HOST2_DEV_ADDR_OUT = addr_vec[1];

    ////////////////////////////////////////////////////////////////////
    // Read mux; address registers are write-only and read zero
    function automatic logic [15:0] rd_mux(input logic [15:0] a,
                                           input logic [15:0] e0,
                                           input logic [15:0] e1,
                                           input logic [15:0] s0,
                                           input logic [15:0] s1);
        logic [15:0] r;
        r = 16'h0000;
        case (a)
            HOST1_INTERRUPT_ENABLE: r = e0;
            HOST2_INTERRUPT_ENABLE: r = e1;
            HOST1_STATUS: r = s0;
            HOST2_STATUS: r = s1;
            default: r = 16'h0000;
        endcase
        return r;
    endfunction

    always_ff @(posedge MCLK_IN) begin
        if (SRST_IN) begin
            cpu_rd_reg <= 16'h0000;
        end else if (CPU_RE_IN) begin
            cpu_rd_reg <= rd_mux(CPU_ADDR_IN, en_vec[0], en_vec[1],
                                 st_vec[0], st_vec[1]);
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (SRST_IN) begin
            ext_rd_reg <= 16'h0000;
        end else if (EXT_HOST_PORT_RE_IN) begin
            ext_rd_reg <= rd_mux(EXT_HOST_PORT_ADDR_IN, en_vec[0],
                                 en_vec[1], st_vec[0], st_vec[1]); // [R11]
        end
    end

    assign CPU_RDATA_OUT = cpu_rd_reg;
    assign EXT_HOST_PORT_RDATA_OUT = ext_rd_reg;
endmodule

//--- tb/uhir_assertions.sv
`timescale 1ns/1ns
module uhir_assertions
    import uhir_pkg::*;
(
    input wire logic MCLK_IN,
    input wire logic SRST_IN,
    input wire logic CPU_WE_IN,
    input wire logic CPU_RE_IN,
    input wire logic [15:0] CPU_ADDR_IN,
    input wire logic [15:0] CPU_WDATA_IN,
    input wire logic [15:0] CPU_RDATA_OUT,
    input wire logic EXT_HOST_PORT_WE_IN,
    input wire logic EXT_HOST_PORT_RE_IN,
    input wire logic [15:0] EXT_HOST_PORT_ADDR_IN,
    input wire logic [15:0] EXT_HOST_PORT_WDATA_IN,
    input wire logic [15:0] EXT_HOST_PORT_RDATA_OUT,
    input wire logic [1:0] SE0_A_IN,
    input wire logic [1:0] SE0_B_IN,
    input wire logic [6:0] HOST1_DEV_ADDR_OUT,
    input wire logic [6:0] HOST2_DEV_ADDR_OUT,
    input wire logic [1:0] HOST_IRQ_OUT
);
    default clocking @(posedge MCLK_IN); endclocking
    default disable iff (SRST_IN);
    ////////////////////////////////////////
    property p_rst_irq;
        $past(SRST_IN) |-> HOST_IRQ_OUT == 2'b00;
    endproperty
    a_rst_irq: assert property (p_rst_irq)
        else $error("irq high after reset");
    property p_addr1;
        CPU_WE_IN && CPU_ADDR_IN == HOST1_TARGET_DEVICE_ADDRESS |=>
            {9'h000, HOST1_DEV_ADDR_OUT} == ($past(CPU_WDATA_IN) & 16'h007f);
    endproperty
    a_addr1: assert property (p_addr1)
        else $error("host1 address not loaded");
    property p_addr2;
        EXT_HOST_PORT_WE_IN && !CPU_WE_IN &&
            EXT_HOST_PORT_ADDR_IN == HOST2_TARGET_DEVICE_ADDRESS |=>
            {9'h000, HOST2_DEV_ADDR_OUT} ==
            ($past(EXT_HOST_PORT_WDATA_IN) & 16'h007f);
    endproperty
    a_addr2: assert property (p_addr2)
        else $error("host2 address not loaded");
    property p_addr_rd;
        CPU_RE_IN && CPU_ADDR_IN == HOST1_TARGET_DEVICE_ADDRESS |=>
            CPU_RDATA_OUT == 16'h0000;
    endproperty
    a_addr_rd: assert property (p_addr_rd)
        else $error("address register readable");
    property p_se0;
        CPU_RE_IN && CPU_ADDR_IN == HOST1_STATUS |=>
            CPU_RDATA_OUT[3:2] == {$past(SE0_B_IN[0]), $past(SE0_A_IN[0])};
    endproperty
    a_se0: assert property (p_se0)
        else $error("line state bits wrong");
    property p_h2_rsv;
        EXT_HOST_PORT_RE_IN && EXT_HOST_PORT_ADDR_IN == HOST2_STATUS |=>
            EXT_HOST_PORT_RDATA_OUT[15:14] == 2'b00;
    endproperty
    a_h2_rsv: assert property (p_h2_rsv)
        else $error("host2 reserved flags set");
    property p_irq_fall;
        |($past(HOST_IRQ_OUT) & ~HOST_IRQ_OUT) |->
            $past(CPU_WE_IN) || $past(EXT_HOST_PORT_WE_IN) || $past(SRST_IN);
    endproperty
    a_irq_fall: assert property (p_irq_fall)
        else $error("irq dropped without write");
    property p_rd_hold;
        !CPU_RE_IN |=> $stable(CPU_RDATA_OUT);
    endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("read data changed");
endmodule

//--- tb/uhir_periph.sv
`timescale 1ns/1ns
module uhir_periph (
    // Two bits per source, bit 12 bus voltage, bit 13 ID
    output logic [15:0] ev_out
);
    initial ev_out = 16'h0000;
    task automatic drive(input int i, input logic v);
        ev_out[i] = v;
    endtask
endmodule

//--- tb/usb_host_irq_addr_regs_tb.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
    num_errors++; $display("mismatch %s exp %h got %h", n, e, g); end end
module usb_host_irq_addr_regs_tb;
    import uhir_pkg::*;
    logic clk = 0, rst = 1, cwe = 0, cre = 0, xwe = 0, xre = 0;
    logic [15:0] cad = 0, cwd = 0, xad = 0, xwd = 0, crd, xrd, ev;
    logic [6:0] a1, a2;
    logic [1:0] irq;
    int num_errors = 0, samples_checked = 0;
    always #20 clk = ~clk;
    uhir_periph p_u (.ev_out(ev));
    uhir_top dut_u (.MCLK_IN(clk), .SRST_IN(rst), .CPU_WE_IN(cwe),
        .CPU_RE_IN(cre), .CPU_ADDR_IN(cad), .CPU_WDATA_IN(cwd),
        .CPU_RDATA_OUT(crd), .EXT_HOST_PORT_WE_IN(xwe),
        .EXT_HOST_PORT_RE_IN(xre), .EXT_HOST_PORT_ADDR_IN(xad),
        .EXT_HOST_PORT_WDATA_IN(xwd), .EXT_HOST_PORT_RDATA_OUT(xrd),
        .FIRST_ENGINE_PORT_A_VBUS_VALID_IN(ev[12]),
        .FIRST_ENGINE_PORT_A_ID_IN(ev[13]), .SOF_EXPIRE_IN(ev[1:0]),
        .WAKE_A_IN(ev[3:2]), .WAKE_B_IN(ev[5:4]), .XFER_DONE_IN(ev[7:6]),
        .SE0_A_IN(ev[9:8]), .SE0_B_IN(ev[11:10]),
        .HOST1_DEV_ADDR_OUT(a1), .HOST2_DEV_ADDR_OUT(a2),
        .HOST_IRQ_OUT(irq));
    ////////////////////////////////////////
    task automatic wr(input int p, input logic [15:0] a, d);
        @(negedge clk);
        if (p == 0) begin cwe = 1; cad = a; cwd = d; end
        else begin xwe = 1; xad = a; xwd = d; end
        @(negedge clk);
        cwe = 0;
        xwe = 0;
    endtask
    task automatic ck(input int p, input logic [15:0] a, e);
        @(negedge clk);
        if (p == 0) begin cre = 1; cad = a; end
        else begin xre = 1; xad = a; end
        @(negedge clk);
        cre = 0;
        xre = 0;
        `CHK($sformatf("reg %h", a), e, (p == 0 ? crd : xrd))
    endtask
    task automatic pulse(input int i);
        p_u.drive(i, 1'b1);
        @(negedge clk);
        p_u.drive(i, 1'b0);
        @(negedge clk);
    endtask
    task automatic finish_test();
        if (num_errors == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    ////////////////////////////////////////
    task automatic t_addr();
        wr(0, HOST1_TARGET_DEVICE_ADDRESS, 16'h005a);
        wr(1, HOST2_TARGET_DEVICE_ADDRESS, 16'h0025);
        `CHK("host1 addr", 7'h5a, a1)
        `CHK("host2 addr", 7'h25, a2)
        ck(0, HOST1_TARGET_DEVICE_ADDRESS, 16'h0000);
        ck(1, 16'hc0fe, 16'h0000);
    endtask
    task automatic t_enable();
        ck(0, HOST1_INTERRUPT_ENABLE, 16'h0000);
        wr(0, HOST1_INTERRUPT_ENABLE, 16'hffff);
        wr(1, HOST2_INTERRUPT_ENABLE, 16'hffff);
        ck(0, HOST1_INTERRUPT_ENABLE, 16'hc2f1);
        ck(0, HOST1_TARGET_DEVICE_ADDRESS, 16'h0000);
        ck(1, HOST2_INTERRUPT_ENABLE, 16'h02f1);
        ck(1, 16'hc0fe, 16'h0000);
    endtask
    task automatic t_sources();
        int bitpos[8] = '{9, 6, 7, 0, 4, 5, 15, 14};
        int i;
        logic [15:0] e, st;
        for (int k = 0; k < 8; k++) begin
            for (int h = 0; h < (k < 6 ? 2 : 1); h++) begin
                i = k < 6 ? 2 * k + h : k + 6;
                st = h ? HOST2_STATUS : HOST1_STATUS;
                e = 16'h0001 << bitpos[k];
                if (k == 4 || k == 5) e |= 16'h0001 << (k - 2);
                if (k < 4) pulse(i);
                else p_u.drive(i, 1'b1);
                repeat (3) @(negedge clk);
                ck(h, st, e);
                `CHK("irq", 1'b1, irq[h])
                if (k > 5) ck(1, HOST2_STATUS, 16'h0000);
                p_u.drive(i, 1'b0);
                repeat (3) @(negedge clk);
                wr(h, st, 16'hffff);
                ck(h, st, 16'h0000);
                `CHK("irq clear", 1'b0, irq[h])
            end
        end
    endtask
    task automatic t_mask();
        pulse(6);
        wr(0, HOST1_INTERRUPT_ENABLE, 16'hfffe);
        `CHK("irq masked", 1'b0, irq[0])
        wr(0, HOST1_INTERRUPT_ENABLE, 16'h0001);
        `CHK("irq enabled", 1'b1, irq[0])
    endtask
    task automatic t_race();
        wr(0, HOST1_STATUS, 16'h0000);
        ck(0, HOST1_STATUS, 16'h0001);
        fork
            wr(0, HOST1_STATUS, 16'h0001);
            begin @(negedge clk); pulse(6); end
        join
        ck(0, HOST1_STATUS, 16'h0001);
        wr(1, HOST1_STATUS, 16'h0001);
        ck(1, HOST1_STATUS, 16'h0000);
    endtask
    task automatic t_reset();
        @(negedge clk);
        rst = 1;
        p_u.drive(13, 1'b1);
        repeat (2) @(negedge clk);
        rst = 0;
        `CHK("addr reset", 7'h00, a1)
        ck(0, HOST1_INTERRUPT_ENABLE, 16'h0000);
        ck(0, HOST1_STATUS, 16'h0000);
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (16) @(negedge clk);
        rst = 0;
        t_addr();
        t_enable();
        t_sources();
        t_mask();
        t_race();
        t_reset();
        finish_test();
    end
    initial begin
        repeat (100000) @(posedge clk);
        num_errors++;
        finish_test();
    end
endmodule
bind uhir_top uhir_assertions chk_u (.*);
